// [hw/fanrb_defs.svh]
// Register offsets, field positions, reset values of the fiber negotiation register bank
`ifndef FANRB_DEFS_SVH
`define FANRB_DEFS_SVH
`define FANRB_IDX_ADV        12'hc04
`define FANRB_IDX_PARTNER    12'hc05
`define FANRB_IDX_EXP        12'hc06
`define FANRB_IDX_LOCNP      12'hc07
`define FANRB_IDX_PARTNER_NP 12'hc08
`define FANRB_IDX_IDENT      12'hc03
`define FANRB_RST_ADV        16'h0020
`define FANRB_RST_LOCNP      16'h2001
`define FANRB_ADV_WMASK      16'hb1e0
`define FANRB_LOCNP_WMASK    16'hb7ff
`define FANRB_BIT_MORE       15
`define FANRB_BIT_TOGGLE     11
`define FANRB_EXP_PARTNER_NP 3
`define FANRB_EXP_LOCAL_NP   2
`define FANRB_EXP_NEW_PAGE   1
`define FANRB_EXP_PARTNER_AN 0
`endif

// [hw/fanrb_pkg.sv]
// Types shared by the fiber negotiation register bank
package fanrb_pkg;
  typedef logic [15:0] fanrb_word_t;
  typedef logic [31:0] fanrb_bus_t;
endpackage

// [hw/fanrb_top.sv]
// Fiber auto-negotiation management register bank with APB slave
// Behaviour
// - Bit 15 advertises next pages; bit 14 zero
// - Bits 13-12 carry the local fault code
// - Bit 8 advertises asymmetric pause
// - Bit 7 advertises symmetric pause
// - Bits 6,5 duplex; reset value 0020h
// - Partner bit 15 shows partner next-page ability
// - Partner bit 14 shows partner acknowledge
// - Partner bits 13-12 show partner fault code
// - Partner bits 8,7 show partner pause abilities
// - Partner bits 6,5 show partner duplex abilities
// - Exp bit 3 set by base page next-page
// - Exp bit 2 is one in fiber mode
// - Exp bit 1 latches pages, read clears
// - Exp bit 0 set on base page
// - Next-page bit 15 marks more pages
// - Bit 13 message kind, reset one; 14 reserved
// - Bit 12 software comply flag
// - Bit 11 toggles against last transmitted
// - Bits 10-0 message code; reset 2001h
// - Identifier word read-only with three fields
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`include "fanrb_defs.svh"

module fanrb_top #(
  parameter logic [5:0] VENDOR_ID_LOW_BITS = 6'h15,  // Arbitrary value
  parameter logic [5:0] MODEL_CODE         = 6'h2a,  // Arbitrary value
  parameter logic [3:0] REVISION_CODE      = 4'h3    // Arbitrary value
) (
  input  wire logic               sys_clk_i,
  input  wire logic               nrst_i,
  input  wire logic               psel_i,
  input  wire logic               penable_i,
  input  wire logic               pwrite_i,
  input  wire logic [15:0]        paddr_i,
  input  wire fanrb_pkg::fanrb_bus_t pwdata_i,
  output fanrb_pkg::fanrb_bus_t   prdata_o,
  output logic                    pready_o,
  output logic                    pslverr_o,
  input  wire logic               fiber_mode_i,
  input  wire logic               base_page_rx_i,
  input  wire logic               next_page_rx_i,
  input  wire fanrb_pkg::fanrb_word_t rx_page_i,
  input  wire logic               negotiation_start_state_i,
  input  wire logic               np_sent_i,
  output fanrb_pkg::fanrb_word_t  tx_base_page_o,
  output fanrb_pkg::fanrb_word_t  tx_next_page_o
);
  import fanrb_pkg::*;

  fanrb_word_t adv;
  fanrb_word_t partner;
  fanrb_word_t partner_np;
  logic [3:0]  exp_flags;
  fanrb_word_t locnp;
  logic        tx_alternation_bit;
  fanrb_word_t exp_word;
  fanrb_word_t ident;
  fanrb_word_t next_rdata;
  logic        hit;
  logic        wr_en;
  logic        rd_en;
  logic [11:0] idx;

  // Word-aligned APB decode; index is byte address over four
  assign idx   = paddr_i[13:2];
  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign pready_o = 1'b1;  // Zero wait states keep the flag timing simple

  // Identifier fields are fixed parameters
  assign ident = {VENDOR_ID_LOW_BITS, MODEL_CODE, REVISION_CODE};

  // Local fiber mode advertises next-page ability, SGMII does not
  assign exp_word = {12'h000, exp_flags[3], fiber_mode_i, exp_flags[1:0]};

  // Advertisement: only writable bits update, bit 14 and reserved stay zero
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      adv <= `FANRB_RST_ADV;
    else if (wr_en && idx == `FANRB_IDX_ADV)
      adv <= pwdata_i[15:0] & `FANRB_ADV_WMASK;
  end

  // Base page sent to the partner mirrors the advertisement word
  assign tx_base_page_o = adv;

  // Partner ability captured from each received base page
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      partner <= 16'h0000;
    else if (base_page_rx_i)
      partner <= rx_page_i & 16'hf1e0;
  end

  // Partner next page captured for reference readback
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      partner_np <= 16'h0000;
    else if (next_page_rx_i)
      partner_np <= rx_page_i;
  end

  // Expansion flags; a new page in the read cycle wins over the clear
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      exp_flags <= 4'h0;
    else
    begin
      if (negotiation_start_state_i)
      begin
        exp_flags[`FANRB_EXP_PARTNER_NP] <= 1'b0;
        exp_flags[`FANRB_EXP_PARTNER_AN] <= 1'b0;
      end
      if (base_page_rx_i && rx_page_i[`FANRB_BIT_MORE])
        exp_flags[`FANRB_EXP_PARTNER_NP] <= 1'b1;
      if (base_page_rx_i)
        exp_flags[`FANRB_EXP_PARTNER_AN] <= 1'b1;
      if (base_page_rx_i || next_page_rx_i)
        exp_flags[`FANRB_EXP_NEW_PAGE] <= 1'b1;
      else if (rd_en && idx == `FANRB_IDX_EXP)
        exp_flags[`FANRB_EXP_NEW_PAGE] <= 1'b0;
      exp_flags[`FANRB_EXP_LOCAL_NP] <= 1'b0;
    end
  end

  // Local next page: writable fields only, toggle is hardware owned
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      locnp <= `FANRB_RST_LOCNP & `FANRB_LOCNP_WMASK;
    else if (wr_en && idx == `FANRB_IDX_LOCNP)
      locnp <= pwdata_i[15:0] & `FANRB_LOCNP_WMASK;
  end

  // Toggle flips each time a next page leaves, so it complements the last one sent
  always_ff @(posedge sys_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      tx_alternation_bit <= 1'b0;
    else if (np_sent_i)
      tx_alternation_bit <= ~tx_alternation_bit;
  end

  // Transmitted next page word
  always_comb
  begin
    tx_next_page_o = locnp;
    tx_next_page_o[`FANRB_BIT_TOGGLE] = tx_alternation_bit;
  end

  // Read mux; unmapped indexes read zero and flag an error
  always_comb
  begin
    next_rdata = 16'h0000;
    hit = 1'b1;
    unique case (idx)
      `FANRB_IDX_IDENT:      next_rdata = ident;
      `FANRB_IDX_ADV:        next_rdata = adv;
      `FANRB_IDX_PARTNER:    next_rdata = partner;
      `FANRB_IDX_EXP:        next_rdata = exp_word;
      `FANRB_IDX_LOCNP:      next_rdata = tx_next_page_o;
      `FANRB_IDX_PARTNER_NP: next_rdata = partner_np;
      default:               hit = 1'b0;
    endcase
  end

  // Read data is registered-free combinational word in the access phase
  assign prdata_o  = {16'h0000, next_rdata};
  assign pslverr_o = psel_i && penable_i && (!hit || (pwrite_i && idx != `FANRB_IDX_ADV && idx != `FANRB_IDX_LOCNP));

  // Checks
  chk_adv_bit14: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !adv[14] && adv[4:0] == 5'h00) else $error("adv reserved bits set");
  chk_adv_write: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    wr_en && idx == `FANRB_IDX_ADV |=> adv == ($past(pwdata_i[15:0]) & 16'hb1e0))
    else $error("adv write lost");
  chk_partner_cap: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    base_page_rx_i |=> partner[15:12] == $past(rx_page_i[15:12]) && partner[8:5] == $past(rx_page_i[8:5]))
    else $error("partner ability not captured");
  chk_exp_np: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    base_page_rx_i && rx_page_i[15] |=> exp_flags[3]) else $error("partner np flag missed");
  chk_exp_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    negotiation_start_state_i && !base_page_rx_i |=> !exp_flags[0] && !exp_flags[3])
    else $error("start state did not clear");
  chk_page_latch: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    next_page_rx_i |=> exp_flags[1] ##1 (exp_flags[1] || $past(rd_en))) else $error("page latch lost");
  chk_page_rdclr: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    rd_en && idx == `FANRB_IDX_EXP && !base_page_rx_i && !next_page_rx_i |=> !exp_flags[1])
    else $error("read did not clear");
  chk_toggle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    np_sent_i |=> tx_next_page_o[11] != $past(tx_next_page_o[11])) else $error("toggle stuck");
  chk_locnp_ro: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !locnp[14] && !locnp[11]) else $error("next page read-only bits set");
  cov_base_page: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) base_page_rx_i ##1 rd_en);
  cov_next_page: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) next_page_rx_i ##[1:4] np_sent_i);
  cov_adv_write: cover property (@(posedge sys_clk_i) disable iff (!nrst_i) wr_en && idx == `FANRB_IDX_ADV);
endmodule // fanrb_top

// [tb/fanrb_partner.sv]
// Link partner model that delivers received code words
`timescale 1ns/1ps
module fanrb_partner (
  input  wire logic        sys_clk_i,
  output logic             base_page_rx_o,
  output logic             next_page_rx_o,
  output logic [15:0]      rx_page_o
);
  initial
  begin
    base_page_rx_o = 1'b0;
    next_page_rx_o = 1'b0;
    rx_page_o      = 16'h0000;
  end

  // One-cycle page pulse; the word is inverted afterwards so no stale copy looks valid
  task automatic send(input logic nxt, input logic [15:0] w);
    base_page_rx_o <= !nxt;
    next_page_rx_o <= nxt;
    rx_page_o      <= w;
    @(posedge sys_clk_i);
    base_page_rx_o <= 1'b0;
    next_page_rx_o <= 1'b0;
    rx_page_o      <= ~w;
  endtask
endmodule // fanrb_partner

// [tb/fanrb_top_tb.sv]
// Self-checking testbench for the fiber negotiation register bank
`timescale 1ns/1ps
module fanrb_top_tb;
  import fanrb_pkg::*;
  logic        sys_clk_i, base_rx, next_rx, pready, pslverr;
  logic        nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        fiber = 1'b1, start = 1'b0, np_sent = 1'b0;
  logic [15:0] paddr = 16'h0000;
  fanrb_bus_t  pwdata = 32'h0, prdata;
  fanrb_word_t rx_page, tx_base, tx_next;
  int          failures = 0;
  int          n_compared = 0;

  fanrb_top #(.VENDOR_ID_LOW_BITS(6'h0b), .MODEL_CODE(6'h11), .REVISION_CODE(4'h6)) i_dut (
    .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .fiber_mode_i(fiber), .base_page_rx_i(base_rx), .next_page_rx_i(next_rx), .rx_page_i(rx_page),
    .negotiation_start_state_i(start), .np_sent_i(np_sent), .tx_base_page_o(tx_base),
    .tx_next_page_o(tx_next));
  fanrb_partner i_partner (.sys_clk_i(sys_clk_i), .base_page_rx_o(base_rx), .next_page_rx_o(next_rx),
    .rx_page_o(rx_page));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    n_compared++;
    if (seen !== want)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; data are taken while stable just before the completing edge
  task automatic apb(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic [15:0] want,
                     input logic werr);
    logic [32:0] got;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {16'h0000, d};
    @(posedge sys_clk_i);
    penable <= 1'b1;
    for (int i = 0; i <= 20; i++)
    begin
      if (i == 20)
        failures++;
      if (i == 20)
        final_report();
      @(posedge sys_clk_i);
      got = {pslverr, prdata};
      if (pready === 1'b1)
        break;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    check($sformatf("apb err %h", a), {31'h0, got[32]}, {31'h0, werr});
    check($sformatf("apb %h", a), wr ? 32'h0 : got[31:0], wr ? 32'h0 : {16'h0000, want});
    @(posedge sys_clk_i);
  endtask

  task automatic t_reset();
    apb(0, 16'h3010, 16'h0, 16'h0020, 0);
    apb(0, 16'h301c, 16'h0, 16'h2001, 0);
    apb(0, 16'h3018, 16'h0, 16'h0004, 0);
    apb(0, 16'h300c, 16'h0, 16'h2d16, 0);
    apb(1, 16'h300c, 16'hffff, 16'h0, 1);
    apb(0, 16'h300c, 16'h0, 16'h2d16, 0);
    apb(0, 16'h3100, 16'h0, 16'h0000, 1);
  endtask

  task automatic t_adv();
    apb(1, 16'h3010, 16'hffff, 16'h0, 0);
    apb(0, 16'h3010, 16'h0, 16'hb1e0, 0);
    check("tx base", tx_base, 32'hb1e0);
    for (int k = 0; k < 4; k++)
    begin
      apb(1, 16'h3010, 16'(k << 12), 16'h0, 0);
      apb(0, 16'h3010, 16'h0, 16'(k << 12), 0);
    end
  endtask

  task automatic t_pages();
    i_partner.send(0, 16'hf1e0);
    apb(0, 16'h3014, 16'h0, 16'hf1e0, 0);
    apb(0, 16'h3018, 16'h0, 16'h000f, 0);
    apb(0, 16'h3018, 16'h0, 16'h000d, 0);
    start <= 1'b1;
    @(posedge sys_clk_i);
    start <= 1'b0;
    i_partner.send(1, 16'h1234);
    apb(0, 16'h3018, 16'h0, 16'h0006, 0);
    apb(0, 16'h3020, 16'h0, 16'h1234, 0);
    fiber <= 1'b0;
    i_partner.send(0, 16'h01a0);
    apb(0, 16'h3018, 16'h0, 16'h0003, 0);
  endtask

  task automatic t_locnp();
    apb(1, 16'h301c, 16'hffff, 16'h0, 0);
    apb(0, 16'h301c, 16'h0, 16'hb7ff, 0);
    np_sent <= 1'b1;
    @(posedge sys_clk_i);
    np_sent <= 1'b0;
    apb(0, 16'h301c, 16'h0, 16'hbfff, 0);
    check("tx next", tx_next, 32'hbfff);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    @(posedge sys_clk_i);
    t_reset();
    t_adv();
    t_pages();
    t_locnp();
    final_report();
  end
endmodule // fanrb_top_tb
